/* pkg/nrews_defines.svh */
// Offsets, field positions, keys and timing counts of the row erase and write sequencer.
// Assumes a 10 MHz system clock on both ends of the serial link.
`ifndef NREWS_DEFINES_SVH
`define NREWS_DEFINES_SVH

// Serial frame: 4 command bits then 16 payload bits, LSB first
`define NREWS_FRAME_LAST 5'h13
`define NREWS_FOURTH_EDGE 5'h3

// Core register addresses reached by the execute command
`define NREWS_SFR_TABLE_POINTER_UPPER 8'hf8
`define NREWS_SFR_TABLE_POINTER_HIGH 8'hf7
`define NREWS_SFR_TABLE_POINTER_LOW 8'hf6
`define NREWS_SFR_OPERATION_CONTROL 8'ha6
`define NREWS_SFR_UNLOCK_KEY 8'ha7
`define NREWS_SFR_EEPROM_ADDRESS_LOW 8'ha9
`define NREWS_SFR_EEPROM_ADDRESS_HIGH 8'haa
`define NREWS_SFR_EEPROM_DATA_LATCH 8'ha8

// Executed instruction opcodes
`define NREWS_OP_LOAD_WORKING 8'h0e
`define NREWS_OP_STORE_WORKING 8'h6e
`define NREWS_OP_BIT_SET 4'h8
`define NREWS_OP_BIT_CLEAR 4'h9

// Operation control bit positions
`define NREWS_CTL_PROGRAM_SPACE_SELECT 7
`define NREWS_CTL_CONFIG_SPACE_SELECT 6
`define NREWS_CTL_ROW_ERASE 4
`define NREWS_CTL_WRITE_ENABLE_GATE 2
`define NREWS_CTL_WRITE_TRIGGER 1

// Unlock keys and panel write control
`define NREWS_UNLOCK_KEY_FIRST 8'h55
`define NREWS_UNLOCK_KEY_SECOND 8'haa
`define NREWS_PANEL_WRITE_CONTROL_ADDR 22'h3c0006
`define NREWS_PANEL_FULL 8'hff

// Programmer register map
`define NREWS_PRG_COMMAND_OFS 4'h0
`define NREWS_PRG_STATUS_OFS 4'h4
`define NREWS_PRG_HOLD_BIT 20
`define NREWS_PRG_WAIT_BIT 21

// Timing
`define NREWS_SYS_CLK_PERIOD_NS 100
`define NREWS_LINK_PERIOD_NS 800
`define NREWS_LINK_HALF_CYCLES (`NREWS_LINK_PERIOD_NS / 2 / `NREWS_SYS_CLK_PERIOD_NS)
`define NREWS_PROGRAM_HOLD_TIME_NS 2000
`define NREWS_DISCHARGE_TIME_NS 1000
`define NREWS_ROW_ERASE_TIME_NS 5000
`define NREWS_EE_WRITE_TIME_NS 4000
`define NREWS_CEIL_CYCLES(t) (((t) + `NREWS_SYS_CLK_PERIOD_NS - 1) / `NREWS_SYS_CLK_PERIOD_NS)
`define NREWS_PROGRAM_HOLD_CYCLES `NREWS_CEIL_CYCLES(`NREWS_PROGRAM_HOLD_TIME_NS)
`define NREWS_DISCHARGE_CYCLES `NREWS_CEIL_CYCLES(`NREWS_DISCHARGE_TIME_NS)
`define NREWS_ROW_ERASE_CYCLES (`NREWS_ROW_ERASE_TIME_NS / `NREWS_SYS_CLK_PERIOD_NS)
`define NREWS_EE_WRITE_CYCLES (`NREWS_EE_WRITE_TIME_NS / `NREWS_SYS_CLK_PERIOD_NS)

`endif

/* pkg/nrews_pkg.sv */
// Types shared by both ends of the row erase and write sequencer.
// Assumes nrews_defines.svh for all numeric constants.
package nrews_pkg;

  typedef enum logic [3:0] {
    NREWS_CMD_EXECUTE = 4'h0,
    NREWS_CMD_LOAD = 4'hc,
    NREWS_CMD_LOAD_ADVANCE = 4'hd,
    NREWS_CMD_LOAD_START = 4'hf
  } nrews_cmd_e;

  typedef enum logic [1:0] {
    NREWS_PRG_IDLE = 2'h0,
    NREWS_PRG_HIGH = 2'h1,
    NREWS_PRG_LOW = 2'h2,
    NREWS_PRG_WAIT = 2'h3
  } nrews_prg_state_e;

  typedef struct packed {
    logic [1:0] clkSync;
    logic [1:0] datSync;
    logic clkPrev;
    logic [4:0] bitCnt;
    logic [19:0] shiftReg;
    logic [7:0] wreg;
    logic [21:0] tablePointer;
    logic [7:0] opControl;
    logic [7:0] panelCtl;
    logic [15:0] eeAddr;
    logic [7:0] eeprom_data_latch;
    logic [1:0] unlockStep;
    logic [63:0] panelBuf;
    logic [7:0] filled;
    logic trigPending;
    logic progHold;
    logic [15:0] hvTimer;
    logic codeProgStrobe;
    logic codeEraseStrobe;
    logic eeWriteStrobe;
    logic hvActive;
  } nrews_target_s;

  typedef struct packed {
    nrews_prg_state_e state;
    logic [4:0] bitCnt;
    logic [19:0] word;
    logic holdProgram;
    logic waitErase;
    logic [15:0] timer;
    logic clk;
    logic dat;
    logic [31:0] rdData;
  } nrews_prog_s;

endpackage

/* pkg/nrews_link_if.sv */
// Serial programming link between the programmer and the target sequencer.
// Assumes the programmer is the only driver of both wires.
`timescale 1ns/1ps
interface nrews_link_if;
  logic serialProgramClock;
  logic serialProgramData;
  modport programmer (output serialProgramClock, output serialProgramData);
  modport target (input serialProgramClock, input serialProgramData);
endinterface

/* rtl/nrews_target.sv */
// Target end: serial command decoder, panel buffer and erase/write sequencer.
// Assumes the link wires come from another clock domain and are slow against sys_clk.
//
// What this block does
// - Code memory programs eight bytes per write
// - Programmer selects single panel writing first
// - Row erase covers 64 bytes before rewrite
// - Code memory when program set, config clear; command 1111 programs code memory whatever the select bits
// - No erase or eeprom write without enable gate; command 1111 programs code memory without it
// - Row erase bit erases pointer's row
// - Write trigger bit starts selected operation
// - Trigger honoured only after 55h then AAh
// - Erase starts at fourth falling clock edge
// - Programmer holds clock low for discharge
// - Programmer waits erase plus discharge time
// - Table pointer picks the panel buffer
// - Command 1101 loads two bytes, advances two
// - Command 1111 loads last bytes, starts programming
// - Eeprom byte at address pair, data latch
// - Eeprom write erases location automatically
// - Eeprom when both select bits clear
// - Eeprom write starts at fourth falling edge
// - Hardware clears trigger when write completes
// - Programmer holds clock low after eeprom write
// - Fourth clock high times programming pulse
// - Pointer unchanged between loading and start
// - Each panel buffer must be full
`timescale 1ns/1ps
`include "nrews_defines.svh"
module nrews_target #(
  parameter int ERASE_CYCLES = `NREWS_ROW_ERASE_CYCLES,
  parameter int EE_WRITE_CYCLES = `NREWS_EE_WRITE_CYCLES
) (
  // Clock and reset
  input logic sys_clk,
  input logic arst_n,
  // Serial link
  nrews_link_if.target lnk,
  // Array side
  output logic codeProgStrobe,
  output logic [63:0] codeProgData,
  output logic codeEraseStrobe,
  output logic [21:0] tablePointer,
  output logic eepromWriteStrobe,
  output logic [15:0] eepromAddress,
  output logic [7:0] eepromData,
  output logic highVoltageActive,
  // Status
  output logic [7:0] operationControl,
  output logic [7:0] panelWriteControl
);

  if (ERASE_CYCLES < 1 || ERASE_CYCLES > 65535 || EE_WRITE_CYCLES < 1
      || EE_WRITE_CYCLES > 65535) begin : g_check
    $error("nrews_target: timer counts must lie in 1..65535");
  end

  localparam logic [15:0] ERASE_LOAD = 16'(ERASE_CYCLES);
  localparam logic [15:0] EE_LOAD = 16'(EE_WRITE_CYCLES);

  nrews_pkg::nrews_target_s r;
  nrews_pkg::nrews_target_s n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic fall;
    logic [19:0] frame;
    logic [7:0] lo;
    logic [7:0] hi;
    logic doWrite;
    logic [7:0] oldVal;
    logic [7:0] val;
    logic [2:0] idx;
    logic [63:0] bufNew;
    logic [7:0] fill;
    logic trig;
    n = r;
    fall = 1'b0;
    frame = 20'h0;
    lo = 8'h0;
    hi = 8'h0;
    doWrite = 1'b0;
    oldVal = 8'h0;
    val = 8'h0;
    idx = 3'h0;
    bufNew = r.panelBuf;
    fill = r.filled;
    trig = 1'b0;
    n.codeProgStrobe = 1'b0;
    n.codeEraseStrobe = 1'b0;
    n.eeWriteStrobe = 1'b0;
    // Only the second stage of each synchroniser feeds logic
    n.clkSync = {r.clkSync[0], lnk.serialProgramClock};
    n.datSync = {r.datSync[0], lnk.serialProgramData};
    n.clkPrev = r.clkSync[1];
    fall = r.clkPrev & ~r.clkSync[1];
    frame = {r.datSync[1], r.shiftReg[19:1]};
    lo = frame[11:4];
    hi = frame[19:12];

    // Array operation timer; trigger bit drops as it runs out
    if (r.hvTimer != 16'h0) begin
      n.hvTimer = r.hvTimer - 16'h1;
      if (r.hvTimer == 16'h1) begin
        n.opControl[`NREWS_CTL_WRITE_TRIGGER] = 1'b0;
      end
    end

    if (fall) begin
      n.shiftReg = frame;
      n.bitCnt = (r.bitCnt == `NREWS_FRAME_LAST) ? 5'h0 : r.bitCnt + 5'h1;

      // Fourth falling edge of the frame after the trigger or start command
      if (r.bitCnt == `NREWS_FOURTH_EDGE) begin
        n.progHold = 1'b0;
        if (r.trigPending) begin
          n.trigPending = 1'b0;
          if (r.opControl[`NREWS_CTL_PROGRAM_SPACE_SELECT]
              && !r.opControl[`NREWS_CTL_CONFIG_SPACE_SELECT]
              && r.opControl[`NREWS_CTL_ROW_ERASE]) begin
            // 64-byte row is tablePointer with its low six bits ignored
            n.codeEraseStrobe = 1'b1;
            n.hvTimer = ERASE_LOAD;
          end else if (!r.opControl[`NREWS_CTL_PROGRAM_SPACE_SELECT]
              && !r.opControl[`NREWS_CTL_CONFIG_SPACE_SELECT]) begin
            // One strobe covers erase and write of the byte
            n.eeWriteStrobe = 1'b1;
            n.hvTimer = EE_LOAD;
          end else begin
            // Config space, or code space with row erase clear: nothing to do, release the trigger
            n.opControl[`NREWS_CTL_WRITE_TRIGGER] = 1'b0;
          end
        end
      end

      if (r.bitCnt == `NREWS_FRAME_LAST) begin
        // Any completed frame other than a key store or a W load breaks the unlock chain
        n.unlockStep = 2'h0;
        idx = {r.tablePointer[2:1], 1'b0};
        bufNew[{idx, 3'h0} +: 8] = lo;
        bufNew[{idx + 3'h1, 3'h0} +: 8] = hi;
        fill = r.filled | (8'h03 << idx);
        unique case (nrews_pkg::nrews_cmd_e'(frame[3:0]))
          nrews_pkg::NREWS_CMD_EXECUTE: begin
            unique case (lo)
              `NREWS_SFR_TABLE_POINTER_UPPER: oldVal = {2'h0, r.tablePointer[21:16]};
              `NREWS_SFR_TABLE_POINTER_HIGH: oldVal = r.tablePointer[15:8];
              `NREWS_SFR_TABLE_POINTER_LOW: oldVal = r.tablePointer[7:0];
              `NREWS_SFR_OPERATION_CONTROL: oldVal = r.opControl;
              `NREWS_SFR_EEPROM_ADDRESS_LOW: oldVal = r.eeAddr[7:0];
              `NREWS_SFR_EEPROM_ADDRESS_HIGH: oldVal = r.eeAddr[15:8];
              `NREWS_SFR_EEPROM_DATA_LATCH: oldVal = r.eeprom_data_latch;
              default: oldVal = 8'h0;
            endcase
            // Instruction word is {hi, lo}: opcode byte then register byte
            if (hi == `NREWS_OP_LOAD_WORKING) begin
              n.wreg = lo;
              // W must be reloaded between the two key stores, so it keeps the chain
              n.unlockStep = r.unlockStep;
            end else if (hi == `NREWS_OP_STORE_WORKING) begin
              doWrite = 1'b1;
              val = r.wreg;
            end else if (hi[7:4] == `NREWS_OP_BIT_SET) begin
              doWrite = 1'b1;
              val = oldVal | (8'h01 << hi[3:1]);
            end else if (hi[7:4] == `NREWS_OP_BIT_CLEAR) begin
              doWrite = 1'b1;
              val = oldVal & ~(8'h01 << hi[3:1]);
            end
            if (doWrite) begin
              unique case (lo)
                `NREWS_SFR_UNLOCK_KEY: begin
                  if (val == `NREWS_UNLOCK_KEY_FIRST) begin
                    n.unlockStep = 2'h1;
                  end else if (val == `NREWS_UNLOCK_KEY_SECOND && r.unlockStep == 2'h1) begin
                    n.unlockStep = 2'h2;
                  end
                end
                `NREWS_SFR_OPERATION_CONTROL: begin
                  // Software never clears the trigger; a completion in this cycle still does
                  trig = n.opControl[`NREWS_CTL_WRITE_TRIGGER];
                  n.opControl = val;
                  n.opControl[`NREWS_CTL_WRITE_TRIGGER] = trig;
                  if (val[`NREWS_CTL_WRITE_TRIGGER]
                      && !r.opControl[`NREWS_CTL_WRITE_TRIGGER]
                      && r.unlockStep == 2'h2
                      && r.opControl[`NREWS_CTL_WRITE_ENABLE_GATE]) begin
                    n.opControl[`NREWS_CTL_WRITE_TRIGGER] = 1'b1;
                    n.trigPending = 1'b1;
                  end
                end
                `NREWS_SFR_TABLE_POINTER_UPPER: n.tablePointer[21:16] = val[5:0];
                `NREWS_SFR_TABLE_POINTER_HIGH: n.tablePointer[15:8] = val;
                `NREWS_SFR_TABLE_POINTER_LOW: n.tablePointer[7:0] = val;
                `NREWS_SFR_EEPROM_ADDRESS_LOW: n.eeAddr[7:0] = val;
                `NREWS_SFR_EEPROM_ADDRESS_HIGH: n.eeAddr[15:8] = val;
                `NREWS_SFR_EEPROM_DATA_LATCH: n.eeprom_data_latch = val;
                default: begin
                end
              endcase
            end
          end
          nrews_pkg::NREWS_CMD_LOAD: begin
            if (r.tablePointer == `NREWS_PANEL_WRITE_CONTROL_ADDR) begin
              n.panelCtl = lo;
            end else begin
              n.panelBuf = bufNew;
              n.filled = fill;
            end
          end
          nrews_pkg::NREWS_CMD_LOAD_ADVANCE: begin
            n.panelBuf = bufNew;
            n.filled = fill;
            n.tablePointer = r.tablePointer + 22'h2;
          end
          nrews_pkg::NREWS_CMD_LOAD_START: begin
            n.panelBuf = bufNew;
            // A half-filled buffer is not programmed; pointer is left alone
            if (fill == `NREWS_PANEL_FULL && !r.progHold) begin
              n.codeProgStrobe = 1'b1;
              n.progHold = 1'b1;
              n.filled = 8'h0;
            end else begin
              n.filled = fill;
            end
          end
          default: begin
          end
        endcase
      end
    end
    n.hvActive = n.progHold | (n.hvTimer != 16'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign codeProgStrobe = r.codeProgStrobe;
  assign codeProgData = r.panelBuf;
  assign codeEraseStrobe = r.codeEraseStrobe;
  assign tablePointer = r.tablePointer;
  assign eepromWriteStrobe = r.eeWriteStrobe;
  assign eepromAddress = r.eeAddr;
  assign eepromData = r.eeprom_data_latch;
  assign highVoltageActive = r.hvActive;
  assign operationControl = r.opControl;
  assign panelWriteControl = r.panelCtl;

endmodule

/* rtl/nrews_programmer.sv */
// Programmer end: shifts one 20-bit frame per command and times the clock holds.
// Assumes software polls busy before writing the next command.
`timescale 1ns/1ps
`include "nrews_defines.svh"
module nrews_programmer #(
  parameter int HALF_CYCLES = `NREWS_LINK_HALF_CYCLES,
  parameter int HOLD_CYCLES = `NREWS_PROGRAM_HOLD_CYCLES,
  parameter int DISCHARGE_CYCLES = `NREWS_DISCHARGE_CYCLES,
  parameter int ERASE_WAIT_CYCLES = `NREWS_ROW_ERASE_CYCLES + `NREWS_DISCHARGE_CYCLES
) (
  // Clock and reset
  input logic sys_clk,
  input logic arst_n,
  // Serial link
  nrews_link_if.programmer lnk,
  // Register port
  input logic [3:0] regAddr,
  input logic [31:0] regWrData,
  input logic regWrite,
  input logic regRead,
  output logic [31:0] regRdData
);

  // The target needs two sync stages plus an edge compare per clock phase
  if (HALF_CYCLES < 3 || HALF_CYCLES > 65535 || HOLD_CYCLES < 1 || HOLD_CYCLES > 65535
      || DISCHARGE_CYCLES < 1 || DISCHARGE_CYCLES > 65535
      || ERASE_WAIT_CYCLES < 1 || ERASE_WAIT_CYCLES > 65535) begin : g_check
    $error("nrews_programmer: counts out of range");
  end

  localparam logic [15:0] HALF_LOAD = 16'(HALF_CYCLES - 1);
  localparam logic [15:0] HOLD_LOAD = 16'(HOLD_CYCLES - 1);
  localparam logic [15:0] DISCHARGE_LOAD = 16'(DISCHARGE_CYCLES - 1);
  localparam logic [15:0] ERASE_WAIT_LOAD = 16'(ERASE_WAIT_CYCLES - 1);

  nrews_pkg::nrews_prog_s r;
  nrews_pkg::nrews_prog_s n;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [4:0] nextBit;
    n = r;
    nextBit = r.bitCnt + 5'h1;
    n.rdData = 32'h0;
    if (regRead && regAddr == `NREWS_PRG_COMMAND_OFS) begin
      n.rdData = {10'h0, r.waitErase, r.holdProgram, r.word};
    end else if (regRead && regAddr == `NREWS_PRG_STATUS_OFS) begin
      n.rdData = {31'h0, r.state != nrews_pkg::NREWS_PRG_IDLE};
    end
    unique case (r.state)
      nrews_pkg::NREWS_PRG_IDLE: begin
        if (regWrite && regAddr == `NREWS_PRG_COMMAND_OFS) begin
          n.word = regWrData[19:0];
          n.holdProgram = regWrData[`NREWS_PRG_HOLD_BIT];
          n.waitErase = regWrData[`NREWS_PRG_WAIT_BIT];
          n.bitCnt = 5'h0;
          n.clk = 1'b1;
          n.dat = regWrData[0];
          n.timer = HALF_LOAD;
          n.state = nrews_pkg::NREWS_PRG_HIGH;
        end
      end
      nrews_pkg::NREWS_PRG_HIGH: begin
        if (r.timer == 16'h0) begin
          n.clk = 1'b0;
          n.timer = HALF_LOAD;
          n.state = nrews_pkg::NREWS_PRG_LOW;
        end else begin
          n.timer = r.timer - 16'h1;
        end
      end
      nrews_pkg::NREWS_PRG_LOW: begin
        if (r.timer != 16'h0) begin
          n.timer = r.timer - 16'h1;
        end else if (r.bitCnt == `NREWS_FRAME_LAST) begin
          n.dat = 1'b0;
          if (r.holdProgram) begin
            n.timer = DISCHARGE_LOAD;
            n.state = nrews_pkg::NREWS_PRG_WAIT;
          end else if (r.waitErase) begin
            n.timer = ERASE_WAIT_LOAD;
            n.state = nrews_pkg::NREWS_PRG_WAIT;
          end else begin
            n.state = nrews_pkg::NREWS_PRG_IDLE;
          end
        end else begin
          n.bitCnt = nextBit;
          n.clk = 1'b1;
          n.dat = r.word[nextBit];
          // Fourth clock stretched high for the programming pulse
          n.timer = (r.holdProgram && nextBit == `NREWS_FOURTH_EDGE) ? HOLD_LOAD
                                                                     : HALF_LOAD;
          n.state = nrews_pkg::NREWS_PRG_HIGH;
        end
      end
      nrews_pkg::NREWS_PRG_WAIT: begin
        // Clock stays low so the array can discharge
        if (r.timer == 16'h0) begin
          n.state = nrews_pkg::NREWS_PRG_IDLE;
        end else begin
          n.timer = r.timer - 16'h1;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign lnk.serialProgramClock = r.clk;
  assign lnk.serialProgramData = r.dat;
  assign regRdData = r.rdData;

endmodule

/* bench/nrews_link_properties.sv */
// Concurrent checks on the serial link and the target's array-side strobes.
// Assumes it sits beside the link interface in the bench top, fed by name.
`timescale 1ns/1ps
module nrews_link_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Link wires
  input wire logic serialProgramClock,
  input wire logic serialProgramData,
  // Target outputs
  input wire logic codeProgStrobe,
  input wire logic codeEraseStrobe,
  input wire logic eepromWriteStrobe,
  input wire logic highVoltageActive,
  input wire logic [7:0] operationControl
);
  ////////////////////////////////////////////////////////////
  // Cycles since the link clock fell; saturates so a long idle never wraps
  logic clkPrev_r;
  logic [3:0] fallAge_r;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      clkPrev_r <= 1'b0;
      fallAge_r <= 4'hf;
    end else begin
      clkPrev_r <= serialProgramClock;
      if (clkPrev_r && !serialProgramClock) begin
        fallAge_r <= 4'h0;
      end else if (fallAge_r != 4'hf) begin
        fallAge_r <= fallAge_r + 4'h1;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_erase_pulse: assert property (codeEraseStrobe |=> !codeEraseStrobe)
    else $error("erase strobe longer than one cycle");
  a_prog_pulse: assert property (codeProgStrobe |=> !codeProgStrobe)
    else $error("program strobe longer than one cycle");
  a_erase_gate: assert property (codeEraseStrobe |-> operationControl[7:6] == 2'h2
    && operationControl[4] && operationControl[2] && operationControl[1])
    else $error("erase without code space, row erase, enable and trigger");
  a_ee_gate: assert property (eepromWriteStrobe |-> operationControl[7:6] == 2'h0
    && operationControl[2] && operationControl[1])
    else $error("eeprom write without both selects clear, enable and trigger");
  a_erase_fall: assert property (codeEraseStrobe |-> fallAge_r inside {[4'h1:4'h6]})
    else $error("erase not tied to a falling link clock");
  a_ee_fall: assert property (eepromWriteStrobe |-> fallAge_r inside {[4'h1:4'h6]})
    else $error("eeprom write not tied to a falling link clock");
  a_erase_hv: assert property (codeEraseStrobe |=> highVoltageActive [*3])
    else $error("high voltage not held after erase start");
  a_trig_clear: assert property (eepromWriteStrobe |-> ##[1:100] !operationControl[1])
    else $error("trigger not cleared after eeprom write");
  a_clk_high: assert property ($rose(serialProgramClock) |=> serialProgramClock [*3])
    else $error("link clock high phase too short");
  a_data_rise: assert property ($changed(serialProgramData) && serialProgramClock
    |-> $rose(serialProgramClock))
    else $error("link data moved while clock high");
endmodule

/* bench/nrews_test.sv */
// Self-checking bench: programmer and target joined over the link interface.
// Assumes software access only through the programmer's register port.
`timescale 1ns/1ps
module nrews_test;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWrData = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [31:0] regRdData;
  logic codeProgStrobe, codeEraseStrobe, eepromWriteStrobe, highVoltageActive;
  logic [63:0] codeProgData, progData;
  logic [21:0] tablePointer, erasePtr, progPtr;
  logic [15:0] eepromAddress;
  logic [7:0] eepromData, operationControl, panelWriteControl;
  logic [23:0] eeSeen;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  int nErase = 0;
  int nProg = 0;
  int nEe = 0;
  nrews_link_if link();
  nrews_programmer nrews_programmer_i (.sys_clk, .arst_n, .lnk(link), .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData);
  nrews_target nrews_target_i (.sys_clk, .arst_n, .lnk(link), .codeProgStrobe, .codeProgData,
    .codeEraseStrobe, .tablePointer, .eepromWriteStrobe, .eepromAddress, .eepromData,
    .highVoltageActive, .operationControl, .panelWriteControl);
  nrews_link_properties nrews_link_properties_i (.sys_clk, .arst_n,
    .serialProgramClock(link.serialProgramClock), .serialProgramData(link.serialProgramData),
    .codeProgStrobe, .codeEraseStrobe, .eepromWriteStrobe, .highVoltageActive, .operationControl);
  initial forever #50 sys_clk = ~sys_clk;
  ////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes are one-cycle flops, so look at them mid-cycle
  always @(negedge sys_clk) begin
    cycles++;
    if (codeEraseStrobe === 1'b1) begin
      nErase++;
      erasePtr = tablePointer;
    end
    if (codeProgStrobe === 1'b1) begin
      nProg++;
      progData = codeProgData;
      progPtr = tablePointer;
    end
    if (eepromWriteStrobe === 1'b1) begin
      nEe++;
      eeSeen = {eepromAddress, eepromData};
    end
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask
  // One frame; waits on the busy flag so no command is lost while a frame runs
  task automatic send(input logic [3:0] c, input logic [15:0] p, input logic h, input logic w);
    logic [31:0] s;
    int n;
    wr(4'h0, {10'h0, w, h, p, c});
    s = 32'h1;
    n = 0;
    while (s[0] !== 1'b0 && n < 3000) begin
      rd(4'h4, s);
      n++;
    end
    if (n == 3000) chk(64'h1, 64'h0);
  endtask
  task automatic ex(input logic [15:0] p);
    send(nrews_pkg::NREWS_CMD_EXECUTE, p, 1'b0, 1'b0);
  endtask
  task automatic mov(input logic [7:0] r, input logic [7:0] v);
    ex({8'h0e, v});
    ex({8'h6e, r});
  endtask
  task automatic bop(input logic set, input logic [2:0] b);
    ex({set ? 4'h8 : 4'h9, b, 1'b0, 8'ha6});
  endtask
  task automatic ptr(input logic [21:0] a);
    mov(8'hf8, {2'h0, a[21:16]});
    mov(8'hf7, a[15:8]);
    mov(8'hf6, a[7:0]);
  endtask
  // Unlock keys, trigger, then a no-op frame followed by the erase wait
  task automatic fire(input logic [7:0] k1, input logic [7:0] k2);
    mov(8'ha7, k1);
    mov(8'ha7, k2);
    bop(1'b1, 3'h1);
    send(nrews_pkg::NREWS_CMD_EXECUTE, 16'h0, 1'b0, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    rd(4'h0, d);
    chk(d, 64'h0);
    chk({operationControl, panelWriteControl, tablePointer}, 64'h0);
    bop(1'b1, 3'h7);
    bop(1'b1, 3'h6);
    ptr(22'h3c0006);
    send(nrews_pkg::NREWS_CMD_LOAD, 16'h0040, 1'b0, 1'b0);
    chk(panelWriteControl, 64'h40);
    send(nrews_pkg::NREWS_CMD_LOAD, 16'h0000, 1'b0, 1'b0);
    chk(panelWriteControl, 64'h0);
    bop(1'b0, 3'h6);
    ptr(22'h012345);
    chk(tablePointer, 64'h012345);
    bop(1'b1, 3'h4);
    fire(8'h55, 8'haa);
    chk(64'(nErase), 64'h0);
    bop(1'b1, 3'h2);
    fire(8'haa, 8'h55);
    chk(64'(nErase), 64'h0);
    fire(8'h55, 8'haa);
    chk(64'(nErase), 64'h1);
    chk(erasePtr[21:6], 64'h048d);
    bop(1'b0, 3'h4);
    ptr(22'h012340);
    for (int i = 0; i < 3; i++) begin
      send(nrews_pkg::NREWS_CMD_LOAD_ADVANCE, {8'h11 + 8'(2 * i), 8'h10 + 8'(2 * i)}, 1'b0, 1'b0);
    end
    send(nrews_pkg::NREWS_CMD_LOAD_START, 16'h1716, 1'b0, 1'b0);
    chk(64'(nProg), 64'h1);
    chk(progData, 64'h1716151413121110);
    chk(progPtr, 64'h012346);
    chk(highVoltageActive, 64'h1);
    send(nrews_pkg::NREWS_CMD_EXECUTE, 16'h0, 1'b1, 1'b0);
    chk(highVoltageActive, 64'h0);
    rd(4'h0, d);
    chk(d, 64'h00100000);
    ptr(22'h012348);
    send(nrews_pkg::NREWS_CMD_LOAD_START, 16'h5a5a, 1'b1, 1'b0);
    chk(64'(nProg), 64'h1);
    bop(1'b1, 3'h6);
    bop(1'b1, 3'h4);
    fire(8'h55, 8'haa);
    chk({32'(nErase), 32'(nEe)}, {32'h1, 32'h0});
    bop(1'b0, 3'h7);
    bop(1'b0, 3'h6);
    bop(1'b0, 3'h4);
    mov(8'ha9, 8'h3c);
    mov(8'haa, 8'h01);
    mov(8'ha8, 8'hc5);
    fire(8'h55, 8'haa);
    chk(64'(nEe), 64'h1);
    chk(eeSeen, 64'h013cc5);
    chk(64'(nErase), 64'h1);
    chk(operationControl[1], 64'h0);
    bop(1'b0, 3'h2);
    chk(operationControl[2], 64'h0);
    close_out();
  end
endmodule
